// *** logic/io_expander.sv ***
// Top of the two-wire sixteen-bit I/O expander with change interrupt
`timescale 1ns/1ps
module io_expander
    import io_expander_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_sel_bit_zero_i,
    input wire logic addr_sel_bit_one_i,
    input wire logic addr_sel_bit_two_i,
    input wire logic [7:0] low_port_pin_i,
    input wire logic [7:0] high_port_pin_i,
    output logic [7:0] low_port_pin_o,
    output logic [7:0] low_port_pin_oe_o,
    output logic [7:0] high_port_pin_o,
    output logic [7:0] high_port_pin_oe_o,
    output logic int_n_o,
    output logic int_n_oe_o
);
    // Synchronised copies of every pin from outside the clock domain
    logic scl_s;
    logic sda_s;
    logic [2:0] addr_sel_s;
    logic [15:0] pins_s;

    sync_two_stage #(.WIDTH(2), .INIT(2'b11)) bus_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({scl_i, sda_i}),
        .sync_o({scl_s, sda_s})
    );

    sync_two_stage #(.WIDTH(19), .INIT(19'h00000)) pin_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({addr_sel_bit_two_i, addr_sel_bit_one_i,
                  addr_sel_bit_zero_i, high_port_pin_i, low_port_pin_i}),
        .sync_o({addr_sel_s, pins_s})
    );

    // Registers
    logic [7:0] drive_value_low_byte;
    logic [7:0] drive_value_high_byte;
    logic [7:0] invert_low_byte;
    logic [7:0] invert_high_byte;
    logic [7:0] direction_low_byte;
    logic [7:0] direction_high_byte;
    logic [2:0] pointer;

    // Bus engine state
    bus_state_t state;
    bus_state_t next_state;
    logic scl_d;
    logic sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw_read;
    logic cmd_phase;
    logic sda_drive_low;
    logic low_seen; // Clock has gone low since the eighth bit's rising edge

    // Edge and condition detection on the second-stage copies only
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_cond = scl_s && scl_d && sda_d && !sda_s;
    wire stop_cond = scl_s && scl_d && !sda_d && sda_s;
    wire byte_done = scl_rise && (bit_cnt == LAST_BIT);
    // The ninth clock ends on the second fall after a byte, not the first
    wire ack_fall = scl_fall && low_seen;
    wire [7:0] next_shift = {shift[6:0], sda_s};
    wire addr_match = (next_shift[7:1] == {ADDR_FIXED, addr_sel_s});

    // Read value of the pointed register
    wire [7:0] pin_low = pins_s[7:0];
    wire [7:0] pin_high = pins_s[15:8];
    logic [7:0] read_value;
    always_comb begin
        unique case (pointer)
            REG_PIN_LEVEL_LOW: read_value = pin_low ^ invert_low_byte;
            REG_PIN_LEVEL_HIGH: read_value = pin_high ^ invert_high_byte;
            REG_DRIVE_VALUE_LOW: read_value = drive_value_low_byte;
            REG_DRIVE_VALUE_HIGH: read_value = drive_value_high_byte;
            REG_INVERT_LOW: read_value = invert_low_byte;
            REG_INVERT_HIGH: read_value = invert_high_byte;
            REG_DIRECTION_LOW: read_value = direction_low_byte;
            REG_DIRECTION_HIGH: read_value = direction_high_byte;
        endcase
    end

    // Byte events
    wire write_data_done = (state == ST_WRITE) && byte_done && !cmd_phase;
    wire read_byte_load = (state == ST_ADDR_ACK || state == ST_READ_ACK)
                          && ack_fall && rw_read;
    // Pointer toggles inside its pair after every data byte
    wire [2:0] pointer_pair = {pointer[2:1], ~pointer[0]};
    wire read_port_low = read_byte_load && (pointer == REG_PIN_LEVEL_LOW);
    wire read_port_high = read_byte_load && (pointer == REG_PIN_LEVEL_HIGH);

    // Next bus state, sequenced on clock edges of the link
    always_comb begin
        next_state = state;
        if (start_cond) begin
            next_state = ST_ADDR;
        end else if (stop_cond) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_ADDR: begin
                    if (byte_done) begin
                        next_state = addr_match ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (ack_fall) begin
                        next_state = rw_read ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (byte_done) begin
                        next_state = ST_WRITE_ACK;
                    end
                end
                ST_WRITE_ACK: begin
                    if (ack_fall) begin
                        next_state = ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (byte_done) begin
                        next_state = ST_READ_ACK;
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise && sda_s) begin
                        next_state = ST_IDLE;
                    end else if (ack_fall) begin
                        next_state = ST_READ;
                    end
                end
            endcase
        end
    end

    // Bus state and bit counting
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            low_seen <= 1'b0;
        end else begin
            state <= next_state;
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (byte_done) begin
                low_seen <= 1'b0;
            end else if (scl_fall) begin
                low_seen <= 1'b1;
            end
            if (start_cond || (ack_fall && state inside {ST_ADDR_ACK,
                    ST_WRITE_ACK, ST_READ_ACK})) begin
                bit_cnt <= 4'h0;
            end else if (scl_rise) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (read_byte_load) begin
                shift <= read_value;
            end else if (scl_rise && state != ST_READ) begin
                shift <= next_shift;
            end else if (scl_fall && state == ST_READ) begin
                shift <= {shift[6:0], 1'b1};
            end
        end
    end

    // Direction and command phase flags
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rw_read <= 1'b0;
            cmd_phase <= 1'b0;
        end else begin
            if (state == ST_ADDR && byte_done) begin
                rw_read <= sda_s;
                cmd_phase <= !sda_s;
            end else if (state == ST_WRITE && byte_done) begin
                cmd_phase <= 1'b0;
            end
        end
    end

    // Register writes and pointer movement
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            drive_value_low_byte <= DRIVE_VALUE_RESET;
            drive_value_high_byte <= DRIVE_VALUE_RESET;
            invert_low_byte <= INVERT_RESET;
            invert_high_byte <= INVERT_RESET;
            direction_low_byte <= DIRECTION_RESET;
            direction_high_byte <= DIRECTION_RESET;
            pointer <= POINTER_RESET;
        end else if (state == ST_WRITE && byte_done && cmd_phase) begin
            pointer <= next_shift[2:0];
        end else if (write_data_done) begin
            unique case (pointer)
                REG_DRIVE_VALUE_LOW: drive_value_low_byte <= next_shift;
                REG_DRIVE_VALUE_HIGH: drive_value_high_byte <= next_shift;
                REG_INVERT_LOW: invert_low_byte <= next_shift;
                REG_INVERT_HIGH: invert_high_byte <= next_shift;
                REG_DIRECTION_LOW: direction_low_byte <= next_shift;
                REG_DIRECTION_HIGH: direction_high_byte <= next_shift;
                default: ;
            endcase
            pointer <= pointer_pair;
        end else if ((state == ST_READ_ACK) && scl_rise) begin
            pointer <= pointer_pair;
        end
    end

    // Data line drive: ack low as receiver, shifted bits as transmitter
    always_comb begin
        sda_drive_low = 1'b0;
        unique case (state)
            // Pull only once the eighth clock is low, never while it is high
            ST_ADDR_ACK: sda_drive_low = low_seen || !scl_s;
            ST_WRITE_ACK: sda_drive_low = low_seen || !scl_s;
            ST_READ: sda_drive_low = !shift[7];
            // Last bit stays until its clock falls, else a false STOP
            ST_READ_ACK: sda_drive_low = !low_seen && scl_s
                                         && !shift[7];
            default: sda_drive_low = 1'b0;
        endcase
    end

    // Per-port interrupt pending flags, cleared by their own read or once no input pin differs from its snapshot
    logic pending_low;
    logic pending_high;

    port_change_detect low_detect (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(pin_low),
        .direction_i(direction_low_byte),
        .read_i(read_port_low),
        .pending_o(pending_low)
    );

    port_change_detect high_detect (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(pin_high),
        .direction_i(direction_high_byte),
        .read_i(read_port_high),
        .pending_o(pending_high)
    );

    // Outputs from flip-flops; data line is released low-only (open drain)
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            int_n_o <= 1'b0;
            int_n_oe_o <= 1'b0;
            low_port_pin_o <= DRIVE_VALUE_RESET;
            high_port_pin_o <= DRIVE_VALUE_RESET;
            low_port_pin_oe_o <= 8'h00;
            high_port_pin_oe_o <= 8'h00;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= sda_drive_low;
            int_n_o <= 1'b0;
            int_n_oe_o <= pending_low || pending_high;
            low_port_pin_o <= drive_value_low_byte;
            high_port_pin_o <= drive_value_high_byte;
            low_port_pin_oe_o <= ~direction_low_byte;
            high_port_pin_oe_o <= ~direction_high_byte;
        end
    end
endmodule

// *** logic/io_expander_pkg.sv ***
// Package of constants for the two-wire sixteen-bit I/O expander
package io_expander_pkg;
    localparam logic [3:0] ADDR_FIXED = 4'h4; // Arbitrary fixed address bits
    localparam logic [2:0] REG_PIN_LEVEL_LOW = 3'h0;
    localparam logic [2:0] REG_PIN_LEVEL_HIGH = 3'h1;
    localparam logic [2:0] REG_DRIVE_VALUE_LOW = 3'h2;
    localparam logic [2:0] REG_DRIVE_VALUE_HIGH = 3'h3;
    localparam logic [2:0] REG_INVERT_LOW = 3'h4;
    localparam logic [2:0] REG_INVERT_HIGH = 3'h5;
    localparam logic [2:0] REG_DIRECTION_LOW = 3'h6;
    localparam logic [2:0] REG_DIRECTION_HIGH = 3'h7;
    localparam logic [7:0] DRIVE_VALUE_RESET = 8'hff;
    localparam logic [7:0] INVERT_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hff;
    localparam logic [2:0] POINTER_RESET = 3'h0;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK,
        ST_READ, ST_READ_ACK
    } bus_state_t;
endpackage

// *** logic/port_change_detect.sv ***
// Per-port change detection for one 8-bit port
`timescale 1ns/1ps
module port_change_detect
    import io_expander_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] level_i,
    input wire logic [7:0] direction_i,
    input wire logic read_i,
    output logic pending_o
);
    logic [7:0] snapshot;
    logic [7:0] next_snapshot;
    logic [1:0] warm;
    // Snapshot keeps following the pins until the synchroniser holds real
    // levels, so reset never leaves a false change behind
    wire primed = &warm;
    wire [7:0] diff = (level_i ^ snapshot) & direction_i;

    // Snapshot taken when the port is read; returning level clears the flag
    // because the comparison is combinational against the snapshot
    assign next_snapshot = (read_i || !primed) ? level_i : snapshot;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            snapshot <= 8'h00;
            warm <= 2'h0;
            pending_o <= 1'b0;
        end else begin
            snapshot <= next_snapshot;
            warm <= warm + {1'b0, !primed};
            // Mismatch after a read clears; a direction flip raises it
            pending_o <= primed && !read_i && (diff != 8'h00);
        end
    end
endmodule

// *** logic/sync_two_stage.sv ***
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module sync_two_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // First stage is read only by the second
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= INIT;
            sync_o <= INIT;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// *** tb/bus_master_model.sv ***
// Two-wire bus master: makes the bus clock and pulls data low
`timescale 1ns/1ps
module bus_master_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // One 125 ns clock; data moves only while the clock is low
    task automatic pulse(input logic b, output logic s);
        #20 sda_low_o = !b;
        #42.5 scl_o = 1'b1;
        #31.25 s = sda_i;
        #31.25 scl_o = 1'b0;
    endtask
    // START from idle, or repeated START from a low clock
    task automatic start();
        #20 sda_low_o = 1'b0;
        #42.5 scl_o = 1'b1;
        #31.25 sda_low_o = 1'b1;
        #31.25 scl_o = 1'b0;
    endtask
    task automatic stop();
        #20 sda_low_o = 1'b1;
        #42.5 scl_o = 1'b1;
        #31.25 sda_low_o = 1'b0;
        #31.25;
    endtask
    // Eight bits MSB first, then the acknowledge clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(d[i], s);
        pulse(1'b1, ack);
    endtask
    // Last byte of a read is left unacknowledged
    task automatic rbyte(input logic nack, output logic [7:0] d,
        output logic ab);
        for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
        pulse(nack, ab);
    endtask
endmodule

// *** tb/io_expander_props.sv ***
// Port-level assertions for the two-wire I/O expander
`timescale 1ns/1ps
module io_expander_props (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [7:0] low_port_pin_i,
    input wire logic [7:0] high_port_pin_i,
    input wire logic [7:0] low_port_pin_o,
    input wire logic [7:0] low_port_pin_oe_o,
    input wire logic [7:0] high_port_pin_oe_o,
    input wire logic int_n_o,
    input wire logic int_n_oe_o
);
    logic [3:0] pin_quiet, bus_quiet;
    logic [15:0] pins_q, oe_q;
    logic scl_q;
    wire pin_move = {high_port_pin_i, low_port_pin_i} != pins_q
        || {high_port_pin_oe_o, low_port_pin_oe_o} != oe_q;
    // Cycles since pins or bus clock moved; saturate so they never wrap
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_quiet <= 4'h0;
            bus_quiet <= 4'h0;
            pins_q <= 16'h0000;
            oe_q <= 16'h0000;
            scl_q <= 1'b1;
        end else begin
            pin_quiet <= pin_move ? 4'h0 : pin_quiet + {3'h0, ~&pin_quiet};
            bus_quiet <= scl_i != scl_q ? 4'h0
                : bus_quiet + {3'h0, ~&bus_quiet};
            pins_q <= {high_port_pin_i, low_port_pin_i};
            oe_q <= {high_port_pin_oe_o, low_port_pin_oe_o};
            scl_q <= scl_i;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence ack_start;
        $rose(scl_i) && sda_oe_o;
    endsequence
    a_open_drain_low: assert property (!sda_o && !int_n_o)
        else $error("open-drain output driven high");
    a_reset_outputs_idle: assert property (disable iff (1'b0)
        rst_i |-> !sda_oe_o && !int_n_oe_o && low_port_pin_oe_o == 8'h00
        && high_port_pin_oe_o == 8'h00 && low_port_pin_o == 8'hff)
        else $error("outputs not idle in reset");
    a_data_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
    a_ack_holds_high: assert property (ack_start |=> sda_oe_o [*8])
        else $error("pulled data released during clock high");
    a_int_rise_cause: assert property (
        $rose(int_n_oe_o) |-> pin_quiet < 4'd12)
        else $error("interrupt raised with no pin change");
    a_int_fall_cause: assert property ($fell(int_n_oe_o)
        |-> pin_quiet < 4'd12 || bus_quiet < 4'd12)
        else $error("interrupt released with no cause");
    a_dir_by_bus: assert property (($changed(low_port_pin_oe_o)
        || $changed(high_port_pin_oe_o)) |-> bus_quiet < 4'd12)
        else $error("pin direction moved without bus write");
    a_drive_by_bus: assert property (
        $changed(low_port_pin_o) |-> bus_quiet < 4'd12)
        else $error("drive value moved without bus write");
endmodule

// *** tb/io_expander_tb.sv ***
// Self-checking bench for the two-wire sixteen-bit I/O expander
`timescale 1ns/1ps
module io_expander_tb;
    import io_expander_pkg::*;
    logic clock_i, rst_i, sda_o, sda_oe_o, int_n_o, int_n_oe_o, scl, sda_low;
    logic [2:0] asel;
    logic [7:0] ext [2], po [2], poe [2], drv [2], inv [2], dir [2];
    wire [7:0] pin [2];
    int err_total = 0, n_tests = 0, cyc = 0;
    // Pulled-up lines: whatever nobody drives reads high or external
    wire sda = !(sda_oe_o || sda_low);
    assign pin[0] = (poe[0] & po[0]) | (~poe[0] & ext[0]);
    assign pin[1] = (poe[1] & po[1]) | (~poe[1] & ext[1]);
    io_expander DUT (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .addr_sel_bit_zero_i(asel[0]), .addr_sel_bit_one_i(asel[1]),
        .addr_sel_bit_two_i(asel[2]), .low_port_pin_i(pin[0]),
        .high_port_pin_i(pin[1]), .low_port_pin_o(po[0]),
        .low_port_pin_oe_o(poe[0]), .high_port_pin_o(po[1]),
        .high_port_pin_oe_o(poe[1]), .int_n_o(int_n_o),
        .int_n_oe_o(int_n_oe_o));
    bus_master_model m (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Expected pin level: driven value on outputs, outside level on inputs
    function automatic logic [7:0] pin_exp(input int k);
        return (~dir[k] & drv[k]) | (dir[k] & ext[k]);
    endfunction
    function automatic logic [7:0] reg_exp(input logic [2:0] r);
        case (r[2:1])
            2'h0: return pin_exp(r[0]) ^ inv[r[0]];
            2'h1: return drv[r[0]];
            2'h2: return inv[r[0]];
            default: return dir[r[0]];
        endcase
    endfunction
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (3) @(posedge clock_i);
        #1 rst_i = 1'b0;
        for (int k = 0; k < 2; k++) begin
            drv[k] = DRIVE_VALUE_RESET;
            inv[k] = INVERT_RESET;
            dir[k] = DIRECTION_RESET;
        end
        wait_clk(8); // Let the synchronisers fill before the first edge
    endtask
    task automatic send(input logic [7:0] b, input logic want_ack);
        logic a;
        m.wbyte(b, a);
        check("ack", {7'h00, !want_ack}, {7'h00, a});
    endtask
    task automatic wr(input logic [2:0] r, input logic [23:0] d,
        input int n);
        logic [2:0] t;
        logic [7:0] v;
        m.start();
        send({ADDR_FIXED, asel, 1'b0}, 1'b1);
        send({5'h00, r}, 1'b1);
        for (int i = 0; i < n; i++) begin
            t = {r[2:1], r[0] ^ i[0]};
            v = d[8 * i +: 8];
            send(v, 1'b1);
            case (t[2:1])
                2'h1: drv[t[0]] = v;
                2'h2: inv[t[0]] = v;
                2'h3: dir[t[0]] = v;
                default: ;
            endcase
        end
        m.stop();
    endtask
    task automatic rd(input logic [2:0] r, input int n);
        logic [7:0] b;
        logic a;
        m.start();
        send({ADDR_FIXED, asel, 1'b0}, 1'b1);
        send({5'h00, r}, 1'b1);
        m.start();
        send({ADDR_FIXED, asel, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.rbyte(i == n - 1, b, a);
            check("read", reg_exp({r[2:1], r[0] ^ i[0]}), b);
        end
        m.stop();
    endtask
    task automatic pins_check();
        for (int k = 0; k < 2; k++) begin
            check("pin_oe", ~dir[k], poe[k]);
            check("pin_out", drv[k], po[k]);
            check("pin_level", pin_exp(k), pin[k]);
        end
    endtask
    task automatic chk_int(input logic want);
        wait_clk(12);
        check("int_n_oe_o", {7'h00, want}, {7'h00, int_n_oe_o});
    endtask
    // Ceiling well above the longest expected run
    initial begin
        forever begin
            @(posedge clock_i);
            cyc++;
            if (cyc >= 90000) begin
                err_total++;
                $display("[FAIL] cycles expected <90000 seen %0d", cyc);
                summarize();
            end
        end
    end
    initial begin
        logic [2:0] r;
        void'($urandom(32'h610b));
        asel = 3'($urandom);
        ext[0] = 8'($urandom);
        ext[1] = 8'($urandom);
        do_reset();
        chk_int(1'b0);
        for (int k = 0; k < 8; k += 2) begin
            rd(3'(k), 2);
        end
        pins_check();
        repeat (8) begin
            r = 3'($urandom);
            wr(r, 24'($urandom), ($urandom % 3) + 1);
            rd(r, 2);
            pins_check();
        end
        wr(3'h1, 24'h3c3c3c, 3);
        rd(3'h2, 2);
        // Interrupt: both ports inputs, plain polarity, fresh snapshot
        wr(3'h6, 24'h00ffff, 2);
        wr(3'h4, 24'h000000, 2);
        rd(3'h0, 2);
        chk_int(1'b0);
        ext[0] = ext[0] ^ 8'h10;
        chk_int(1'b1);
        ext[0] = ext[0] ^ 8'h10;
        chk_int(1'b0);
        ext[1] = ext[1] ^ 8'h01;
        chk_int(1'b1);
        rd(3'h0, 1);
        chk_int(1'b1);
        rd(3'h1, 1);
        chk_int(1'b0);
        // Port 0 as outputs driving the opposite level: no interrupt
        wr(3'h2, {16'h0000, ~ext[0]}, 1);
        wr(3'h6, 24'h000000, 1);
        chk_int(1'b0);
        ext[0] = ext[0] ^ 8'h0f;
        chk_int(1'b0);
        rd(3'h0, 1);
        wr(3'h6, 24'h0000ff, 1);
        chk_int(1'b1);
        rd(3'h0, 1);
        chk_int(1'b0);
        // Foreign address is left unacknowledged
        m.start();
        send({~ADDR_FIXED, asel, 1'b0}, 1'b0);
        m.stop();
        rd(3'h2, 1);
        // Reset in mid-run brings back every default
        do_reset();
        chk_int(1'b0);
        rd(3'h2, 2);
        rd(3'h6, 2);
        pins_check();
        summarize();
    end
endmodule
bind io_expander io_expander_props props (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .low_port_pin_i(low_port_pin_i),
    .high_port_pin_i(high_port_pin_i),
    .low_port_pin_o(low_port_pin_o),
    .low_port_pin_oe_o(low_port_pin_oe_o),
    .high_port_pin_oe_o(high_port_pin_oe_o),
    .int_n_o(int_n_o),
    .int_n_oe_o(int_n_oe_o)
);
